/* File: sdcp_host.sv */
`timescale 1ns/1ns
module sdcp_host (
  input  wire logic clk,
  output logic      sclk,
  output logic      serial_bit_stream,
  output logic      strobe,
  output logic      gate_n
);
  // serial clock stands low between frames
  initial begin
    sclk = 1'b0;
    serial_bit_stream = 1'b1;
    strobe = 1'b0;
    gate_n = 1'b0;
  end

  task automatic send(input logic [10:0] w, input logic do_load);
    @(posedge clk) gate_n <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      // data moves one cycle after the fall, so each half of the serial clock is 8 cycles
      @(posedge clk) serial_bit_stream <= w[i];
      repeat (7) @(posedge clk);
      sclk <= 1'b1;
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    if (do_load) begin
      strobe <= 1'b1;
      repeat (8) @(posedge clk);
      strobe <= 1'b0;
    end
    // released data line must not keep its last level
    @(posedge clk) serial_bit_stream <= ~w[10];
    gate_n <= 1'b0;
  endtask : send
endmodule : sdcp_host

/* File: sdcp_pkg.sv */
// Operation
// - shift one bit per serial clock rise
// - channel select bit shifted in first
// - word: code high, mode, channel lowest
// - channel bit picks channel a or b
// - mode 0: two independent delay paths
// - mode 1: input a through both channels
// - mode 1: output pair a held off
// - code picks 512 steps, 11 ps each
// - strobe high transparent, falling edge holds
// - held word ignores later serial activity
// - routing muxes driven by latched bits
package sdcp_pkg;

  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int WORD_W   = 11;
  localparam int CODE_W   = 9;
  localparam int CHAN_POS = 0;
  localparam int MODE_POS = 1;
  localparam int CODE_POS = 2;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic              mode;
    logic              chan;
  } sdcp_word_t;

  // ---------------------------------------------------------------
  // delay scale
  // ---------------------------------------------------------------
  localparam int PS_W      = 13;
  localparam int SUM_W     = 14;
  localparam logic [PS_W-1:0] STEP_PS = 13'h00b;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_RST = 11'h000;
  localparam logic [CODE_W-1:0] CODE_RST = 9'h000;

  // synchronised input bundle
  typedef struct packed {
    logic sclk;
    logic serial_bit_stream;
    logic strobe;
    logic gate_n;
    logic a_t;
    logic a_c;
    logic b_t;
    logic b_c;
  } sdcp_pins_t;

  localparam int PINS_W = 8;

endpackage : sdcp_pkg

/* File: sdcp_port.sv */
`timescale 1ns/1ns
module sdcp_port (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          serial_shift_clk,
  input  wire logic                          serial_data_input,
  input  wire logic                          load_strobe,
  input  wire logic                          input_gate_n,
  input  wire logic                          input_pair_a_t,
  input  wire logic                          input_pair_a_c,
  input  wire logic                          input_pair_b_t,
  input  wire logic                          input_pair_b_c,
  output logic                               output_pair_a_t,
  output logic                               output_pair_a_c,
  output logic                               output_pair_b_t,
  output logic                               output_pair_b_c,
  output logic [sdcp_pkg::CODE_W-1:0]        delay_channel_a,
  output logic [sdcp_pkg::CODE_W-1:0]        delay_channel_b,
  output logic                               mode_select_bit,
  output logic [sdcp_pkg::PS_W-1:0]          delay_a_ps,
  output logic [sdcp_pkg::PS_W-1:0]          delay_b_ps,
  output logic [sdcp_pkg::SUM_W-1:0]         path_b_delay_ps
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  sdcp_pkg::sdcp_pins_t pins_raw;
  sdcp_pkg::sdcp_pins_t pins_s;

  assign pins_raw = '{sclk: serial_shift_clk, serial_bit_stream: serial_data_input,
                      strobe: load_strobe, gate_n: input_gate_n,
                      a_t: input_pair_a_t, a_c: input_pair_a_c,
                      b_t: input_pair_b_t, b_c: input_pair_b_c};

  sdcp_sync #(.W(sdcp_pkg::PINS_W)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pins_raw),
    .q   (pins_s)
  );

  // ---------------------------------------------------------------
  // serial shift register
  // ---------------------------------------------------------------
  logic                              sclk_prev_q;
  logic                              sclk_rise;
  logic [sdcp_pkg::WORD_W-1:0]       sreg_q;
  logic [sdcp_pkg::WORD_W-1:0]       sreg_d;

  assign sclk_rise = pins_s.sclk & ~sclk_prev_q;

  always_comb begin
    sreg_d = sreg_q;
    if (sclk_rise) begin
      // new bits enter at the top so the first bit ends at the bottom
      sreg_d = {pins_s.serial_bit_stream, sreg_q[sdcp_pkg::WORD_W-1:1]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
      sreg_q      <= sdcp_pkg::WORD_RST;
    end else begin
      sclk_prev_q <= pins_s.sclk;
      sreg_q      <= sreg_d;
    end
  end

  // ---------------------------------------------------------------
  // data latch
  // ---------------------------------------------------------------
  sdcp_pkg::sdcp_word_t              latch_q;
  sdcp_pkg::sdcp_word_t              latch_d;
  logic                              upd_q;
  logic [sdcp_pkg::CODE_W-1:0]       lat_code;
  logic                              lat_mode;
  logic                              lat_chan;

  assign lat_code = latch_q.code;
  assign lat_mode = latch_q.mode;
  assign lat_chan = latch_q.chan;

  always_comb begin
    latch_d = latch_q;
    if (pins_s.strobe) begin
      latch_d = sdcp_pkg::sdcp_word_t'(sreg_q);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_q <= sdcp_pkg::sdcp_word_t'(sdcp_pkg::WORD_RST);
      upd_q   <= 1'b0;
    end else begin
      latch_q <= latch_d;
      upd_q   <= pins_s.strobe;
    end
  end

  // ---------------------------------------------------------------
  // channel codes and mode
  // ---------------------------------------------------------------
  logic [sdcp_pkg::CODE_W-1:0]       code_a_d;
  logic [sdcp_pkg::CODE_W-1:0]       code_b_d;
  logic                              mode_d;

  always_comb begin
    code_a_d = delay_channel_a;
    code_b_d = delay_channel_b;
    mode_d   = mode_select_bit;
    if (upd_q) begin
      if (lat_chan) begin
        code_b_d = lat_code;
      end else begin
        code_a_d = lat_code;
      end
      mode_d = lat_mode;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delay_channel_a <= sdcp_pkg::CODE_RST;
      delay_channel_b <= sdcp_pkg::CODE_RST;
      mode_select_bit <= 1'b0;
    end else begin
      delay_channel_a <= code_a_d;
      delay_channel_b <= code_b_d;
      mode_select_bit <= mode_d;
    end
  end

  // ---------------------------------------------------------------
  // delay figures
  // ---------------------------------------------------------------
  logic [sdcp_pkg::PS_W-1:0]         dly_a_d;
  logic [sdcp_pkg::PS_W-1:0]         dly_b_d;
  logic [sdcp_pkg::SUM_W-1:0]        path_d;

  always_comb begin
    dly_a_d = sdcp_pkg::PS_W'(delay_channel_a) * sdcp_pkg::STEP_PS;
    dly_b_d = sdcp_pkg::PS_W'(delay_channel_b) * sdcp_pkg::STEP_PS;
    if (mode_select_bit) begin
      path_d = sdcp_pkg::SUM_W'(dly_a_d) + sdcp_pkg::SUM_W'(dly_b_d);
    end else begin
      path_d = sdcp_pkg::SUM_W'(dly_b_d);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delay_a_ps      <= '0;
      delay_b_ps      <= '0;
      path_b_delay_ps <= '0;
    end else begin
      delay_a_ps      <= dly_a_d;
      delay_b_ps      <= dly_b_d;
      path_b_delay_ps <= path_d;
    end
  end

  // ---------------------------------------------------------------
  // signal routing
  // ---------------------------------------------------------------
  logic oa_t_d;
  logic oa_c_d;
  logic ob_t_d;
  logic ob_c_d;

  always_comb begin
    // idle pair: true low, complement high
    oa_t_d = 1'b0;
    oa_c_d = 1'b1;
    ob_t_d = 1'b0;
    ob_c_d = 1'b1;
    // gate high blocks inputs during loading
    if (!pins_s.gate_n) begin
      if (mode_select_bit) begin
        ob_t_d = pins_s.a_t;
        ob_c_d = pins_s.a_c;
      end else begin
        oa_t_d = pins_s.a_t;
        oa_c_d = pins_s.a_c;
        ob_t_d = pins_s.b_t;
        ob_c_d = pins_s.b_c;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_pair_a_t <= 1'b0;
      output_pair_a_c <= 1'b1;
      output_pair_b_t <= 1'b0;
      output_pair_b_c <= 1'b1;
    end else begin
      output_pair_a_t <= oa_t_d;
      output_pair_a_c <= oa_c_d;
      output_pair_b_t <= ob_t_d;
      output_pair_b_c <= ob_c_d;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_shift_advance: assert property (sclk_rise |=>
    sreg_q == (({$past(pins_s.serial_bit_stream), 10'h000}) | ($past(sreg_q) >> 1)))
    else $error("shift register did not advance by one");

  a_shift_idle: assert property (!sclk_rise |=> $stable(sreg_q))
    else $error("shift register moved without a clock rise");

  a_latch_follow: assert property (pins_s.strobe |=> latch_q == $past(sreg_q))
    else $error("latch not transparent while strobe high");

  a_latch_hold: assert property (!pins_s.strobe |=> $stable(latch_q))
    else $error("latch changed while strobe low");

  a_chan_a_load: assert property (upd_q && !lat_chan |=>
    delay_channel_a == $past(lat_code))
    else $error("channel a code not loaded");

  a_chan_other_kept: assert property (upd_q && lat_chan |=> $stable(delay_channel_a))
    else $error("channel a changed on a channel b load");

  a_mode_follow: assert property (upd_q |=> mode_select_bit == $past(lat_mode))
    else $error("mode not taken from latest word");

  a_cascade_off: assert property (mode_select_bit |=>
    !output_pair_a_t && output_pair_a_c)
    else $error("pair a not held off in cascade");

  a_cascade_route: assert property (mode_select_bit && !pins_s.gate_n |=>
    output_pair_b_t == $past(pins_s.a_t))
    else $error("cascade did not route input a to pair b");

  a_dual_route: assert property (!mode_select_bit && !pins_s.gate_n |=>
    output_pair_a_t == $past(pins_s.a_t) && output_pair_b_t == $past(pins_s.b_t))
    else $error("dual mode paths not independent");

  a_delay_scale: assert property (##1 delay_a_ps ==
    sdcp_pkg::PS_W'($past(delay_channel_a)) * 13'h00b)
    else $error("delay a not eleven ps per step");

  a_cascade_sum: assert property (mode_select_bit |=>
    path_b_delay_ps == sdcp_pkg::SUM_W'($past(dly_a_d)) + sdcp_pkg::SUM_W'($past(dly_b_d)))
    else $error("cascade delay is not the sum");

  a_chan_b_load: assert property (upd_q && lat_chan |=>
    delay_channel_b == $past(lat_code))
    else $error("channel b code not loaded");

  a_chan_b_kept: assert property (upd_q && !lat_chan |=> $stable(delay_channel_b))
    else $error("channel b changed on a channel a load");

  a_code_hold: assert property (!upd_q |=>
    $stable(delay_channel_a) && $stable(delay_channel_b) && $stable(mode_select_bit))
    else $error("stored codes changed without a latch update");

  a_gate_idle: assert property (pins_s.gate_n |=>
    !output_pair_a_t && output_pair_a_c && !output_pair_b_t && output_pair_b_c)
    else $error("outputs not idle while input gate is high");

  a_delay_b_scale: assert property (##1 delay_b_ps ==
    sdcp_pkg::PS_W'($past(delay_channel_b)) * sdcp_pkg::STEP_PS)
    else $error("delay b not eleven ps per step");

endmodule : sdcp_port

/* File: sdcp_port_tb_top.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module sdcp_port_tb_top;
  logic                          clk;
  logic                          rst;
  logic                          sclk;
  logic                          serial_bit_stream;
  logic                          strobe;
  logic                          gate_n;
  logic                          in_at;
  logic                          in_ac;
  logic                          in_bt;
  logic                          in_bc;
  logic                          out_at;
  logic                          out_ac;
  logic                          out_bt;
  logic                          out_bc;
  logic [sdcp_pkg::CODE_W-1:0]   code_a;
  logic [sdcp_pkg::CODE_W-1:0]   code_b;
  logic                          mode;
  logic [sdcp_pkg::PS_W-1:0]     ps_a;
  logic [sdcp_pkg::PS_W-1:0]     ps_b;
  logic [sdcp_pkg::SUM_W-1:0]    ps_path;
  int                            err_count = 0;
  int                            check_count = 0;
  int                            cyc = 0;

  sdcp_host i_sdcp_host (.clk(clk), .sclk(sclk), .serial_bit_stream(serial_bit_stream), .strobe(strobe),
    .gate_n(gate_n));

  sdcp_port i_sdcp_port (.clk(clk), .rst(rst), .serial_shift_clk(sclk),
    .serial_data_input(serial_bit_stream), .load_strobe(strobe), .input_gate_n(gate_n),
    .input_pair_a_t(in_at), .input_pair_a_c(in_ac), .input_pair_b_t(in_bt),
    .input_pair_b_c(in_bc), .output_pair_a_t(out_at), .output_pair_a_c(out_ac),
    .output_pair_b_t(out_bt), .output_pair_b_c(out_bc), .delay_channel_a(code_a),
    .delay_channel_b(code_b), .mode_select_bit(mode), .delay_a_ps(ps_a),
    .delay_b_ps(ps_b), .path_b_delay_ps(ps_path));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  task automatic load(input logic [8:0] c, input logic m, input logic ch);
    sdcp_pkg::sdcp_word_t w;
    w.code = c;
    w.mode = m;
    w.chan = ch;
    i_sdcp_host.send(w, 1'b1);
    repeat (8) @(posedge clk);
  endtask : load

  task automatic chk_cfg(input logic [8:0] a, input logic [8:0] b, input logic m);
    logic [12:0] ea;
    logic [12:0] eb;
    ea = 13'(a) * sdcp_pkg::STEP_PS;
    eb = 13'(b) * sdcp_pkg::STEP_PS;
    `CHK(code_a, a)
    `CHK(code_b, b)
    `CHK(mode, m)
    `CHK(ps_a, ea)
    `CHK(ps_b, eb)
    `CHK(ps_path, m ? 14'(ea) + 14'(eb) : 14'(eb))
  endtask : chk_cfg

  // pins and expected outputs are {a_t, a_c, b_t, b_c}
  task automatic route(input logic [3:0] pins, input logic [3:0] e);
    {in_at, in_ac, in_bt, in_bc} <= pins;
    repeat (5) @(posedge clk);
    `CHK({out_at, out_ac, out_bt, out_bc}, e)
  endtask : route

  // ---------------------------------------------------------------
  // hang guard: a full run takes about 1000 cycles
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {in_at, in_ac, in_bt, in_bc} = 4'h5;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_cfg(9'h000, 9'h000, 1'b0);
    route(4'h9, 4'h9);
    route(4'h6, 4'h6);
    load(9'h1ff, 1'b0, 1'b0);
    chk_cfg(9'h1ff, 9'h000, 1'b0);
    load(9'h001, 1'b0, 1'b1);
    chk_cfg(9'h1ff, 9'h001, 1'b0);
    // shifting without a strobe must leave the held word alone
    i_sdcp_host.send(11'h555, 1'b0);
    repeat (8) @(posedge clk);
    chk_cfg(9'h1ff, 9'h001, 1'b0);
    load(9'h1fe, 1'b1, 1'b1);
    chk_cfg(9'h1ff, 9'h1fe, 1'b1);
    route(4'h9, 4'h6);
    route(4'h6, 4'h5);
    load(9'h0aa, 1'b0, 1'b0);
    chk_cfg(9'h0aa, 9'h1fe, 1'b0);
    route(4'h9, 4'h9);
    end_sim();
  end
endmodule : sdcp_port_tb_top

/* File: sdcp_sync.sv */
`timescale 1ns/1ns
module sdcp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : sdcp_sync
